/* File: logic/mesf_top.sv */
/*
 * Monitor error-status flag bank: sticky fault flags for voltage channels
 * nine to sixteen, the two terminator fuse inputs and the two remote
 * sensor diodes, read and cleared over an internal byte register port.
 * Assumes readings, bounds and diode verdicts come from the conversion
 * engine on I_CLK, and that the terminator sense pins are asynchronous.
 */
// Behaviour
// RQ1: Channels nine..sixteen set bits zero..seven.
// RQ2: Each channel judged against own bound pair.
// RQ3: Terminator inputs set bits two and three.
// RQ4: Sensor A open/short sets bit six.
// RQ5: Sensor B open/short sets bit seven.
// RQ6: Flags reset zero, write-one clears, reserved zero.
`timescale 1ns/1ps
`include "mesf_defs.svh"

module mesf_top #(
    parameter int NCH = `MESF_NUM_VOLT_CH         // Voltage channels in this bank.
) (
    input  wire logic                   I_CLK,            // System clock, 100 MHz.
    input  wire logic                   I_ARST_N,         // Asynchronous reset, active low.
    input  wire logic [NCH-1:0]         I_VOLT_VALID,     // Per-channel new-reading pulse.
    input  wire logic [NCH-1:0][7:0]    I_VOLT_READING,   // Per-channel converted voltage.
    input  wire logic [NCH-1:0][7:0]    I_VOLT_LO_LIMIT,  // Per-channel lower bound.
    input  wire logic [NCH-1:0][7:0]    I_VOLT_HI_LIMIT,  // Per-channel upper bound.
    input  wire logic                   I_TERMINATOR_SENSE_A, // Fuse pin A, async, high.
    input  wire logic                   I_TERMINATOR_SENSE_B, // Fuse pin B, async, high.
    input  wire logic                   I_SENSOR_A_OPEN,  // Remote sensor A open verdict.
    input  wire logic                   I_SENSOR_A_SHORT, // Remote sensor A short verdict.
    input  wire logic                   I_SENSOR_B_OPEN,  // Remote sensor B open verdict.
    input  wire logic                   I_SENSOR_B_SHORT, // Remote sensor B short verdict.
    input  wire logic [7:0]             I_REG_ADDR,       // Register address.
    input  wire logic                   I_REG_WR,         // One-cycle write strobe.
    input  wire logic [7:0]             I_REG_WDATA,      // Write data, ones clear flags.
    input  wire logic                   I_REG_RD,         // One-cycle read strobe.
    output logic [7:0]                  O_REG_RDATA,      // Read data, one cycle after strobe.
    output logic                        O_REG_RVALID,     // Read data valid pulse.
    output logic [7:0]                  O_VOLT_HI_FLAGS,  // Voltage flag register view.
    output logic [7:0]                  O_FUSE_DIODE_FLAGS // Fuse and diode register view.
);

    // Registered out-of-window pulses, one per channel.
    mesf_pkg::mesf_ch_vec_t volt_fault;

    // Sticky flag registers.
    mesf_pkg::mesf_byte_t   volt_hi_flags_q;    // Voltage channel error flags.
    mesf_pkg::mesf_byte_t   volt_hi_flags_d;    // Next value of the voltage flags.
    mesf_pkg::mesf_byte_t   fuse_diode_flags_q; // Fuse and diode error flags.
    mesf_pkg::mesf_byte_t   fuse_diode_flags_d; // Next value of fuse and diode flags.

    // Terminator pin synchronisers, three stages each.
    logic [2:0]             term_a_sync_q;      // Stage 0 feeds stage 1 only.
    logic [2:0]             term_b_sync_q;      // Stage 0 feeds stage 1 only.
    logic                   term_a_level_q;     // Debounced fuse A level.
    logic                   term_b_level_q;     // Debounced fuse B level.

    // Per-register set and clear vectors.
    mesf_pkg::mesf_byte_t   volt_set;           // Hardware set requests.
    mesf_pkg::mesf_byte_t   volt_clr;           // Software clear requests.
    mesf_pkg::mesf_byte_t   fd_set;             // Hardware set requests.
    mesf_pkg::mesf_byte_t   fd_clr;             // Software clear requests.

    // Read data and its valid pulse.
    mesf_pkg::mesf_byte_t   rdata_q;            // Captured read data.
    logic                   rvalid_q;           // Read data valid.

    // One comparator per channel, each with its own bound pair.
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_cmp
            mesf_window_cmp #(
                .W          (8)
            ) u_cmp (
                .i_clk      (I_CLK),
                .i_arst_n   (I_ARST_N),
                .i_valid    (I_VOLT_VALID[ch]),
                .i_reading  (I_VOLT_READING[ch]),
                .i_lo_limit (I_VOLT_LO_LIMIT[ch]), // [RQ2]
                .i_hi_limit (I_VOLT_HI_LIMIT[ch]), // [RQ2]
                .o_fault    (volt_fault[ch])
            );
        end
    endgenerate

    // Shift the terminator pins through three flip-flops.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            term_a_sync_q <= 3'h0;
            term_b_sync_q <= 3'h0;
        end else begin
            term_a_sync_q <= {term_a_sync_q[1:0], I_TERMINATOR_SENSE_A};
            term_b_sync_q <= {term_b_sync_q[1:0], I_TERMINATOR_SENSE_B};
        end
    end

    // Accept a new pin level only once stages one and two agree.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            term_a_level_q <= 1'b0;
            term_b_level_q <= 1'b0;
        end else begin
            if (term_a_sync_q[1] == term_a_sync_q[2]) begin
                term_a_level_q <= term_a_sync_q[2];
            end
            if (term_b_sync_q[1] == term_b_sync_q[2]) begin
                term_b_level_q <= term_b_sync_q[2];
            end
        end
    end

    // Build set and clear vectors; clears only hit bits that exist.
    always_comb begin
        volt_set = volt_fault;                       // [RQ1]
        fd_set   = 8'h00;
        fd_set[`MESF_BIT_FUSE_A]   = term_a_level_q; // [RQ3]
        fd_set[`MESF_BIT_FUSE_B]   = term_b_level_q; // [RQ3]
        fd_set[`MESF_BIT_SENSOR_A] = I_SENSOR_A_OPEN || I_SENSOR_A_SHORT; // [RQ4]
        fd_set[`MESF_BIT_SENSOR_B] = I_SENSOR_B_OPEN || I_SENSOR_B_SHORT; // [RQ5]
        volt_clr = 8'h00;
        fd_clr   = 8'h00;
        if (I_REG_WR && (I_REG_ADDR == `MESF_ADDR_VOLT_HI)) begin
            volt_clr = I_REG_WDATA & `MESF_MASK_VOLT_HI;     // [RQ6]
        end
        if (I_REG_WR && (I_REG_ADDR == `MESF_ADDR_FUSE_DIODE)) begin
            fd_clr = I_REG_WDATA & `MESF_MASK_FUSE_DIODE;    // [RQ6]
        end
    end

    // Next flag values: a set in the same cycle as a clear wins.
    always_comb begin
        volt_hi_flags_d    = ((volt_hi_flags_q & ~volt_clr) | volt_set)
                             & `MESF_MASK_VOLT_HI;           // [RQ1] [RQ6]
        fuse_diode_flags_d = ((fuse_diode_flags_q & ~fd_clr) | fd_set)
                             & `MESF_MASK_FUSE_DIODE;        // [RQ6]
    end

    // Voltage flag register.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            volt_hi_flags_q <= `MESF_FLAGS_RESET;            // [RQ6]
        end else begin
            volt_hi_flags_q <= volt_hi_flags_d;
        end
    end

    // Fuse and diode flag register.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fuse_diode_flags_q <= `MESF_FLAGS_RESET;         // [RQ6]
        end else begin
            fuse_diode_flags_q <= fuse_diode_flags_d;
        end
    end

    // Register read port; an unmapped address reads zero.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= I_REG_RD;
            if (I_REG_RD) begin
                case (I_REG_ADDR)
                    `MESF_ADDR_VOLT_HI: begin
                        rdata_q <= volt_hi_flags_q;
                    end
                    `MESF_ADDR_FUSE_DIODE: begin
                        rdata_q <= fuse_diode_flags_q;       // [RQ6]
                    end
                    default: begin
                        rdata_q <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Drive the outputs straight from flip-flops.
    assign O_REG_RDATA        = rdata_q;
    assign O_REG_RVALID       = rvalid_q;
    assign O_VOLT_HI_FLAGS    = volt_hi_flags_q;
    assign O_FUSE_DIODE_FLAGS = fuse_diode_flags_q;

    // A channel fault pulse always leaves its own bit set next cycle.
    property p_volt_set;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (volt_fault != 8'h00) |=> ((volt_hi_flags_q & $past(volt_fault)) == $past(volt_fault));
    endproperty
    a_volt_set: assert property (p_volt_set) else $error("Voltage flag not set."); // [RQ1]

    // The debounced fuse A level sets bit two even during a clear.
    property p_fuse_a;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        term_a_level_q |=> fuse_diode_flags_q[`MESF_BIT_FUSE_A];
    endproperty
    a_fuse_a: assert property (p_fuse_a) else $error("Fuse A flag not set."); // [RQ3]

    // A fuse pin held high for five cycles reaches bit three.
    property p_fuse_b_pin;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        I_TERMINATOR_SENSE_B [*5] |=> fuse_diode_flags_q[`MESF_BIT_FUSE_B];
    endproperty
    a_fuse_b_pin: assert property (p_fuse_b_pin) else $error("Fuse B pin missed."); // [RQ3]

    // Sensor A open or short sets bit six.
    property p_sensor_a;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_SENSOR_A_OPEN || I_SENSOR_A_SHORT) |=> fuse_diode_flags_q[`MESF_BIT_SENSOR_A];
    endproperty
    a_sensor_a: assert property (p_sensor_a) else $error("Sensor A flag not set."); // [RQ4]

    // Sensor B open or short sets bit seven.
    property p_sensor_b;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_SENSOR_B_OPEN || I_SENSOR_B_SHORT) |=> fuse_diode_flags_q[`MESF_BIT_SENSOR_B];
    endproperty
    a_sensor_b: assert property (p_sensor_b) else $error("Sensor B flag not set."); // [RQ5]

    // A flag stays set unless software writes a one to it.
    property p_sticky;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (volt_clr == 8'h00) |=> ((volt_hi_flags_q & $past(volt_hi_flags_q))
                                 == $past(volt_hi_flags_q));
    endproperty
    a_sticky: assert property (p_sticky) else $error("Voltage flag lost."); // [RQ6]

    // A write-one with no set pending clears the bit.
    property p_w1c;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (fd_clr[`MESF_BIT_SENSOR_A] && !fd_set[`MESF_BIT_SENSOR_A])
            |=> !fuse_diode_flags_q[`MESF_BIT_SENSOR_A];
    endproperty
    a_w1c: assert property (p_w1c) else $error("Write-one did not clear."); // [RQ6]

    // Reserved bits of the fuse and diode register always read zero.
    property p_reserved;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        rvalid_q |-> ((rdata_q & ~`MESF_MASK_FUSE_DIODE) == 8'h00
                      || $past(I_REG_ADDR) != `MESF_ADDR_FUSE_DIODE);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bit read one."); // [RQ6]

endmodule // mesf_top

/* File: logic/mesf_defs.svh */
/*
 * Named constants for the monitor error-status flag bank: register
 * addresses, field positions, reset values and writable-bit masks.
 * Assumes it is included by bare name from design files.
 */
`ifndef MESF_DEFS_SVH
`define MESF_DEFS_SVH

// Register addresses on the internal register port.
`define MESF_ADDR_VOLT_HI      8'h4a
`define MESF_ADDR_FUSE_DIODE   8'h4b

// Reset value shared by both flag registers.
`define MESF_FLAGS_RESET       8'h00

// Field positions in the fuse and diode register.
`define MESF_BIT_FUSE_A        2
`define MESF_BIT_FUSE_B        3
`define MESF_BIT_SENSOR_A      6
`define MESF_BIT_SENSOR_B      7

// Bits that exist in each register; all others read zero.
`define MESF_MASK_VOLT_HI      8'hff
`define MESF_MASK_FUSE_DIODE   8'hcc

// Voltage channel count handled by this bank (channels nine to sixteen).
`define MESF_NUM_VOLT_CH       8

`endif

/* File: logic/mesf_pkg.sv */
/*
 * Types shared by the monitor error-status flag bank.
 * Assumes nothing of its surroundings; it is referenced as mesf_pkg::name.
 */
package mesf_pkg;
    // One byte of register data or one converted reading.
    typedef logic [7:0] mesf_byte_t;
    // One flag per monitored voltage channel.
    typedef logic [7:0] mesf_ch_vec_t;
endpackage

/* File: logic/mesf_window_cmp.sv */
/*
 * Window comparator for one voltage channel: flags a fresh reading that
 * lies below its lower bound or above its upper bound.
 * Assumes reading, bounds and valid come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "mesf_defs.svh"

module mesf_window_cmp #(
    parameter int W = 8                    // Width of a reading and its bounds.
) (
    input  wire logic         i_clk,       // System clock.
    input  wire logic         i_arst_n,    // Asynchronous reset, active low.
    input  wire logic         i_valid,     // One-cycle pulse: a new reading.
    input  wire logic [W-1:0] i_reading,   // Converted channel voltage.
    input  wire logic [W-1:0] i_lo_limit,  // Lower bound of this channel.
    input  wire logic [W-1:0] i_hi_limit,  // Upper bound of this channel.
    output logic              o_fault      // One-cycle pulse: reading out of window.
);
    // Outside the window when strictly below lower or strictly above upper.
    logic out_of_window;                   // Combinational range verdict.
    assign out_of_window = (i_reading < i_lo_limit) || (i_reading > i_hi_limit); // [RQ2]

    // Register the verdict so the flag bank sees a clean pulse.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fault <= 1'b0;
        end else begin
            o_fault <= i_valid && out_of_window; // [RQ2]
        end
    end

    // A low reading raises the fault one cycle later.
    property p_below_low;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_valid && (i_reading < i_lo_limit)) |=> o_fault;
    endproperty
    a_below_low: assert property (p_below_low) else $error("Low reading not flagged."); // [RQ2]

    // A reading inside its own window never raises the fault.
    property p_inside_quiet;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_reading >= i_lo_limit && i_reading <= i_hi_limit) |=> !o_fault;
    endproperty
    a_inside_quiet: assert property (p_inside_quiet) // [RQ2]
        else $error("In-range reading flagged.");
endmodule // mesf_window_cmp

/* File: verif/mesf_far_side.sv */
/*
 * Model of the conversion engine beside the flag bank: it converts one
 * voltage channel per clock, round robin, and pulses that channel's valid.
 * Assumes the bench presents channel levels off the rising clock edge.
 */
`timescale 1ns/1ps

module mesf_far_side (
    input  wire logic            i_clk,     // System clock.
    input  wire logic            i_arst_n,  // Asynchronous reset, active low.
    input  wire logic [7:0][7:0] i_level,   // Voltage present on each channel.
    output logic      [7:0]      o_valid,   // One-hot conversion pulse.
    output logic      [7:0][7:0] o_reading  // Readings, only one of them fresh.
);
    logic [2:0] ch_q;  // Channel converted next.

    // Channels not being converted show inverted levels, so a bank that
    // samples a reading without its valid pulse sees a wrong value.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ch_q      <= 3'h0;
            o_valid   <= 8'h00;
            o_reading <= '0;
        end else begin
            ch_q    <= ch_q + 3'h1;
            o_valid <= 8'h01 << ch_q;
            for (int k = 0; k < 8; k++) begin
                o_reading[k] <= (k == int'(ch_q)) ? i_level[k] : ~i_level[k];
            end
        end
    end
endmodule // mesf_far_side

/* File: verif/test_mesf_top.sv */
/*
 * Self-checking bench for the error flag bank: drives channels, pins and
 * sensor verdicts, then reads and clears flags over the register port.
 * Assumes the far-side model file and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "mesf_defs.svh"

module test_mesf_top;
    logic            clk = 1'b0;     // System clock.
    logic            arst_n = 1'b0;  // Reset, active low.
    logic [7:0][7:0] level, lo, hi;  // Channel levels and bounds.
    logic [7:0]      valid;          // Conversion pulses.
    logic [7:0][7:0] reading;        // Converted readings.
    logic            fuse_a, fuse_b; // Terminator pins.
    logic [3:0]      diode;          // A open, A short, B open, B short.
    logic [7:0]      addr, wdata;    // Register request.
    logic            wr, rd, rvalid; // Strobes and read answer.
    logic [7:0]      rdata, vflags, fflags; // Read data and register views.
    int              failures = 0;   // Mismatches seen.
    int              compares = 0;   // Comparisons made.
    int              i;              // Loop index.

    mesf_far_side mesf_far_side_i (.i_clk(clk), .i_arst_n(arst_n), .i_level(level),
        .o_valid(valid), .o_reading(reading));

    mesf_top mesf_top_i (.I_CLK(clk), .I_ARST_N(arst_n), .I_VOLT_VALID(valid),
        .I_VOLT_READING(reading), .I_VOLT_LO_LIMIT(lo), .I_VOLT_HI_LIMIT(hi),
        .I_TERMINATOR_SENSE_A(fuse_a), .I_TERMINATOR_SENSE_B(fuse_b),
        .I_SENSOR_A_OPEN(diode[0]), .I_SENSOR_A_SHORT(diode[1]),
        .I_SENSOR_B_OPEN(diode[2]), .I_SENSOR_B_SHORT(diode[3]),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_VOLT_HI_FLAGS(vflags),
        .O_FUSE_DIODE_FLAGS(fflags));

    // Clock of 10 ns period.
    always #5 clk = ~clk;

    // Counts a comparison and reports a mismatch.
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One write strobe, raised and dropped on falling edges.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // One read strobe; the answer is awaited under a bound.
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clk);
        if (k == 4) begin
            failures++;
            conclude();
        end else begin
            d = rdata;
        end
    endtask

    // Reads until the expected byte shows or the bound runs out, then
    // compares the read data and the matching register view.
    task automatic check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        int n;
        reg_rd(a, d);
        for (n = 0; n < 12 && d !== exp; n++) reg_rd(a, d);
        cmp(d, exp);
        if (a == `MESF_ADDR_VOLT_HI) cmp(vflags, exp);
        if (a == `MESF_ADDR_FUSE_DIODE) cmp(fflags, exp);
    endtask

    // Main sequence; every channel has its own bounds and sits on its lower one.
    initial begin
        {fuse_a, fuse_b, wr, rd, diode, addr, wdata} = '0;
        for (i = 0; i < 8; i++) begin
            lo[i] = 8'h10 + 8'(i * 8);
            hi[i] = 8'he0 - 8'(i * 8);
            level[i] = lo[i];
        end
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        check(`MESF_ADDR_VOLT_HI, 8'h00);
        check(`MESF_ADDR_FUSE_DIODE, 8'h00);
        // Each channel leaves its window, below on even and above on odd.
        for (i = 0; i < 8; i++) begin
            level[i] = (i % 2) ? hi[i] + 8'h01 : lo[i] - 8'h01;
            check(`MESF_ADDR_VOLT_HI, 8'h01 << i);
            level[i] = (i % 2) ? hi[i] : lo[i];
            reg_wr(`MESF_ADDR_VOLT_HI, 8'h00);
            check(`MESF_ADDR_VOLT_HI, 8'h01 << i);
            reg_wr(`MESF_ADDR_VOLT_HI, 8'h01 << i);
            check(`MESF_ADDR_VOLT_HI, 8'h00);
        end
        // Terminator pins, then an unmapped place.
        fuse_a = 1'b1;
        check(`MESF_ADDR_FUSE_DIODE, 8'h04);
        fuse_a = 1'b0;
        fuse_b = 1'b1;
        check(`MESF_ADDR_FUSE_DIODE, 8'h0c);
        fuse_b = 1'b0;
        reg_wr(8'h4c, 8'hff);
        check(8'h4c, 8'h00);
        // The unmapped write must leave the real fuse flags untouched.
        check(`MESF_ADDR_FUSE_DIODE, 8'h0c);
        // Pins pass a synchroniser, so let the release settle first.
        repeat (8) @(negedge clk);
        reg_wr(`MESF_ADDR_FUSE_DIODE, 8'hff);
        check(`MESF_ADDR_FUSE_DIODE, 8'h00);
        // Open and short on each remote sensor.
        for (i = 0; i < 4; i++) begin
            diode = 4'h1 << i;
            check(`MESF_ADDR_FUSE_DIODE, (i < 2) ? 8'h40 : 8'h80);
            diode = 4'h0;
            reg_wr(`MESF_ADDR_FUSE_DIODE, (i < 2) ? 8'h40 : 8'h80);
            check(`MESF_ADDR_FUSE_DIODE, 8'h00);
        end
        // A second reset in mid-run clears a standing flag.
        diode = 4'h8;
        check(`MESF_ADDR_FUSE_DIODE, 8'h80);
        arst_n = 1'b0;
        diode = 4'h0;
        @(negedge clk);
        arst_n = 1'b1;
        check(`MESF_ADDR_FUSE_DIODE, 8'h00);
        conclude();
    end
endmodule // test_mesf_top
